/* File: logic/core_status_option_irq_regs.v */
// Core status, option, interrupt-control and peripheral-enable registers
// Operation
// [RULE1] Flag-affecting instruction overrides written Z, DC, C
// [RULE2] Timeout and power-down bits ignore writes
// [RULE3] Two direct bank bits pick 128-byte bank
// [RULE4] Indirect bank bit picks banks 0-1 or 2-3
// [RULE5] Timeout flag set on powerup/clear/sleep, cleared on timeout
// [RULE6] Power-down flag set on powerup/clear, cleared on sleep
// [RULE7] Zero flag follows whether result is zero
// [RULE8] Nibble carry from bit 3, inverted for borrow
// [RULE9] Carry from msb; borrow inverted; rotate loads it
// [RULE10] Software alters status only with non-flag instructions
// [RULE11] Software keeps status bits 7:6 cleared
// [RULE12] Option bit 7 disables all port-B pull-ups
// [RULE13] Option bit 6 selects external interrupt edge
// [RULE14] Option bit 5 selects timer0 clock source
// [RULE15] Option bit 4 selects timer0 external edge
// [RULE16] Option bit 3 assigns prescaler; timer0 then 1:1
// [RULE17] Rate n divides timer0 2^(n+1), watchdog 2^n
// [RULE18] Flags set regardless of enables
// [RULE19] Global enable gates all; peripheral enable gates peripherals
// [RULE20] Timer0 overflow sets flag; enable bit 5; software clears
// [RULE21] External pin edge sets flag; enable bit 4
// [RULE22] Port-B high nibble change sets flag; enable bit 3
// [RULE23] Peripheral enable bit order fixed
// [RULE24] Peripheral enables pair with same-position flags
// [RULE25] Interrupt request from enabled flags under global enable
`timescale 1ns/1ps
`include "core_sfr_map.vh"

module core_status_option_irq_regs #(
    parameter PORT_BITS = 4
) (
    // Clock and reset
    input  wire                 clock,
    input  wire                 rst,
    // Instruction unit register access
    input  wire [8:0]           reg_addr,
    input  wire                 reg_wr,
    input  wire [7:0]           reg_wdata,
    output reg  [7:0]           reg_rdata,
    // Instruction result flags
    input  wire                 flags_upd_z,
    input  wire                 flags_upd_dc,
    input  wire                 flags_upd_c,
    input  wire                 result_zero,
    input  wire                 result_dc,
    input  wire                 result_c,
    // Watchdog and power events
    input  wire                 watchdog_clear_instr,
    input  wire                 sleep_instr,
    input  wire                 wdt_timeout,
    // Event sources
    input  wire                 timer0_overflow,
    input  wire                 ext_irq_pin,
    input  wire [PORT_BITS-1:0] port_b_hi_pins,
    input  wire                 port_b_read,
    input  wire [7:0]           periph_flags,
    // Configuration outputs
    output reg  [1:0]           direct_bank,
    output reg                  indirect_bank_sel,
    output reg                  pullup_disable_n,
    output reg                  ext_irq_edge_sel,
    output reg                  timer0_clk_src,
    output reg                  timer0_ext_edge,
    output reg                  prescaler_assign,
    output reg  [2:0]           prescaler_rate,
    output reg  [3:0]           timer0_div_log2,
    output reg  [3:0]           wdt_div_log2,
    output reg  [7:0]           peripheral_irq_enable_out,
    output reg                  irq_request
);

    reg  [7:0]           status_r;
    reg  [7:0]           option_r;
    reg  [7:0]           intctl_r;
    reg  [7:0]           pie_r;
    reg                  ext_s1_r;
    reg                  ext_s2_r;
    reg                  ext_s3_r;
    reg  [PORT_BITS-1:0] pb_s1_r;
    reg  [PORT_BITS-1:0] pb_s2_r;
    reg  [PORT_BITS-1:0] pb_latch_r;
    reg  [7:0]           status_nxt;
    reg  [7:0]           intctl_nxt;
    reg  [7:0]           rdata_nxt;
    reg                  irq_nxt;

    wire sel_status = (reg_addr == `STATUS_ADDR) || (reg_addr == `STATUS_ADDR_ALT);
    wire sel_intctl = (reg_addr == `INTCTL_ADDR) || (reg_addr == `INTCTL_ADDR_ALT);
    wire sel_option = (reg_addr == `OPTION_ADDR);
    wire sel_pie    = (reg_addr == `PIE_ADDR);

    // Edge detection only on the second and third stages
    wire ext_rise = ext_s2_r & ~ext_s3_r;
    wire ext_fall = ~ext_s2_r & ext_s3_r;
    wire ext_edge = option_r[`OPT_EDGE] ? ext_rise : ext_fall;                 // [RULE13]
    // Mismatch against last latched value persists until port read
    wire pb_mismatch = (pb_s2_r != pb_latch_r);                                  // [RULE22]

    always @* begin
        status_nxt = status_r;
        if (reg_wr && sel_status) begin
            status_nxt[7:5] = reg_wdata[7:5];                                     // [RULE3] [RULE4]
            status_nxt[`ST_ZERO] = reg_wdata[`ST_ZERO];
            status_nxt[`ST_DC]   = reg_wdata[`ST_DC];
            status_nxt[`ST_C]    = reg_wdata[`ST_C];                              // [RULE2]
        end
        // Result flags override any write of the same bits
        if (flags_upd_z)
            status_nxt[`ST_ZERO] = result_zero;                                  // [RULE1] [RULE7]
        if (flags_upd_dc)
            status_nxt[`ST_DC] = result_dc;                                      // [RULE1] [RULE8]
        if (flags_upd_c)
            status_nxt[`ST_C] = result_c;                                        // [RULE1] [RULE9]
        if (watchdog_clear_instr) begin
            status_nxt[`ST_WDT] = 1'b1;                                           // [RULE5]
            status_nxt[`ST_PD]  = 1'b1;                                           // [RULE6]
        end else if (sleep_instr) begin
            status_nxt[`ST_WDT] = 1'b1;                                           // [RULE5]
            status_nxt[`ST_PD]  = 1'b0;                                           // [RULE6]
        end
        if (wdt_timeout)
            status_nxt[`ST_WDT] = 1'b0;                                           // [RULE5]
    end

    always @* begin
        intctl_nxt = intctl_r;
        if (reg_wr && sel_intctl)
            intctl_nxt = reg_wdata;
        // Hardware set wins over a same-cycle software clear
        if (timer0_overflow)
            intctl_nxt[`IC_T0F] = 1'b1;                                           // [RULE20] [RULE18]
        if (ext_edge)
            intctl_nxt[`IC_EXTF] = 1'b1;                                          // [RULE21] [RULE18]
        if (pb_mismatch)
            intctl_nxt[`IC_PCF] = 1'b1;                                           // [RULE22] [RULE18]
    end

    always @* begin
        irq_nxt = intctl_r[`IC_GIE] & (                                           // [RULE19] [RULE25]
                  (intctl_r[`IC_T0EN]  & intctl_r[`IC_T0F]) |
                  (intctl_r[`IC_EXTEN] & intctl_r[`IC_EXTF]) |
                  (intctl_r[`IC_PCEN]  & intctl_r[`IC_PCF]) |
                  (intctl_r[`IC_PERIPH_IRQ_EN]  & |(pie_r & periph_flags)));               // [RULE24]
    end

    always @* begin
        rdata_nxt = 8'h00;
        if (sel_status)
            rdata_nxt = status_r;
        else if (sel_intctl)
            rdata_nxt = intctl_r;
        else if (sel_option)
            rdata_nxt = option_r;
        else if (sel_pie)
            rdata_nxt = pie_r;
    end

    always @(posedge clock) begin
        if (rst) begin
            status_r   <= `STATUS_RST;
            option_r   <= `OPTION_RST;
            intctl_r   <= `INTCTL_RST;
            pie_r      <= `PIE_RST;
            ext_s1_r   <= 1'b0;
            ext_s2_r   <= 1'b0;
            ext_s3_r   <= 1'b0;
            pb_s1_r    <= {PORT_BITS{1'b0}};
            pb_s2_r    <= {PORT_BITS{1'b0}};
            pb_latch_r <= {PORT_BITS{1'b0}};
        end else begin
            status_r <= status_nxt;
            intctl_r <= intctl_nxt;
            if (reg_wr && sel_option)
                option_r <= reg_wdata;
            if (reg_wr && sel_pie)
                pie_r <= reg_wdata;                                               // [RULE23]
            ext_s1_r <= ext_irq_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            pb_s1_r  <= port_b_hi_pins;
            pb_s2_r  <= pb_s1_r;
            // Reading the port ends the mismatch
            if (port_b_read)
                pb_latch_r <= pb_s2_r;                                            // [RULE22]
        end
    end

    // Registered copies of configuration fields
    always @(posedge clock) begin
        if (rst) begin
            reg_rdata                 <= 8'h00;
            direct_bank               <= 2'b00;
            indirect_bank_sel         <= 1'b0;
            pullup_disable_n          <= 1'b1;
            ext_irq_edge_sel          <= 1'b1;
            timer0_clk_src            <= 1'b1;
            timer0_ext_edge           <= 1'b1;
            prescaler_assign          <= 1'b1;
            prescaler_rate            <= 3'h7;
            timer0_div_log2           <= 4'h0;
            wdt_div_log2              <= 4'h7;
            peripheral_irq_enable_out <= 8'h00;
            irq_request               <= 1'b0;
        end else begin
            reg_rdata                 <= rdata_nxt;
            direct_bank               <= status_nxt[`ST_RPHI:`ST_RPLO];           // [RULE3]
            indirect_bank_sel         <= status_nxt[`ST_IBANK];                   // [RULE4]
            pullup_disable_n          <= (reg_wr && sel_option) ? reg_wdata[`OPT_PULLUP]
                                                                : option_r[`OPT_PULLUP];        // [RULE12]
            ext_irq_edge_sel          <= option_r[`OPT_EDGE];                     // [RULE13]
            timer0_clk_src            <= option_r[`OPT_T0SRC];                    // [RULE14]
            timer0_ext_edge           <= option_r[`OPT_T0EDGE];                   // [RULE15]
            prescaler_assign          <= option_r[`OPT_PSA];                      // [RULE16]
            prescaler_rate            <= option_r[2:0];
            // Timer0 runs 1:1 while watchdog owns the prescaler
            timer0_div_log2           <= option_r[`OPT_PSA] ? 4'h0
                                                            : ({1'b0, option_r[2:0]} + 4'h1); // [RULE16] [RULE17]
            wdt_div_log2              <= option_r[`OPT_PSA] ? {1'b0, option_r[2:0]}
                                                            : 4'h0;                           // [RULE17]
            peripheral_irq_enable_out <= pie_r;                                   // [RULE23]
            irq_request               <= irq_nxt;                                 // [RULE25]
        end
    end

endmodule // core_status_option_irq_regs

/* File: include/core_sfr_map.vh */
// Offsets, field positions, reset values of the core special-function registers
`ifndef CORE_SFR_MAP_VH
`define CORE_SFR_MAP_VH
`define STATUS_ADDR      9'h003
`define STATUS_ADDR_ALT  9'h083
`define INTCTL_ADDR      9'h00b
`define INTCTL_ADDR_ALT  9'h08b
`define OPTION_ADDR      9'h081
`define PIE_ADDR         9'h08c
`define ST_IBANK         7
`define ST_RPHI          6
`define ST_RPLO          5
`define ST_WDT           4
`define ST_PD            3
`define ST_ZERO          2
`define ST_DC            1
`define ST_C             0
`define OPT_PULLUP       7
`define OPT_EDGE         6
`define OPT_T0SRC        5
`define OPT_T0EDGE       4
`define OPT_PSA          3
`define IC_GIE           7
`define IC_PERIPH_IRQ_EN          6
`define IC_T0EN          5
`define IC_EXTEN         4
`define IC_PCEN          3
`define IC_T0F           2
`define IC_EXTF          1
`define IC_PCF           0
`define STATUS_RST       8'h18
`define OPTION_RST       8'hff
`define INTCTL_RST       8'h00
`define PIE_RST          8'h00
`endif

/* File: testbench/core_status_option_irq_regs_chk.sv */
// Assertion checker watching the core register bank ports
`timescale 1ns/1ps
`include "core_sfr_map.vh"
module core_regs_chk (
    // Clock, reset and register access
    input wire       clock, rst, reg_wr,
    input wire [8:0] reg_addr,
    input wire [7:0] reg_wdata, periph_flags, peripheral_irq_enable_out,
    // Configuration outputs
    input wire [1:0] direct_bank,
    input wire [2:0] prescaler_rate,
    input wire [3:0] timer0_div_log2, wdt_div_log2,
    input wire       indirect_bank_sel, pullup_disable_n, ext_irq_edge_sel, timer0_clk_src,
    input wire       timer0_ext_edge, prescaler_assign, irq_request
);
    // Last written data; flags set by hardware are not tracked here
    reg  [7:0] opt_w_r, st_w_r, pie_w_r, ic_w_r;
    wire       opt_wr = reg_wr && reg_addr == `OPTION_ADDR;
    wire       st_wr  = reg_wr && (reg_addr == `STATUS_ADDR || reg_addr == `STATUS_ADDR_ALT);
    wire       pie_wr = reg_wr && reg_addr == `PIE_ADDR;
    wire       ic_wr  = reg_wr && (reg_addr == `INTCTL_ADDR || reg_addr == `INTCTL_ADDR_ALT);
    always @(posedge clock) begin
        if (opt_wr) opt_w_r <= reg_wdata;
        if (st_wr) st_w_r <= reg_wdata;
        if (pie_wr) pie_w_r <= reg_wdata;
        ic_w_r <= rst ? 8'h00 : (ic_wr ? reg_wdata : ic_w_r);
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    t0_div_a: assert property (!prescaler_assign |-> timer0_div_log2 == {1'b0, prescaler_rate} + 4'h1)
        else $error("timer0 divider wrong");
    wdt_div_a: assert property (prescaler_assign |->
            timer0_div_log2 == 4'h0 && wdt_div_log2 == {1'b0, prescaler_rate})
        else $error("watchdog divider wrong");
    pullup_edge_a: assert property (opt_wr |-> ##[1:2] {pullup_disable_n, ext_irq_edge_sel} == opt_w_r[7:6])
        else $error("pull-up or edge field wrong");
    t0_source_a: assert property (opt_wr |-> ##[1:2] {timer0_clk_src, timer0_ext_edge} == opt_w_r[5:4])
        else $error("timer0 source field wrong");
    rate_field_a: assert property (opt_wr |-> ##[1:2] {prescaler_assign, prescaler_rate} == opt_w_r[3:0])
        else $error("prescaler field wrong");
    bank_sel_a: assert property (st_wr |-> ##[1:2] {indirect_bank_sel, direct_bank} == st_w_r[7:5])
        else $error("bank select wrong");
    pie_copy_a: assert property (pie_wr |-> ##[1:2] peripheral_irq_enable_out == pie_w_r)
        else $error("peripheral enables wrong");
    irq_gate_a: assert property (!ic_w_r[7] && !$past(ic_w_r[7]) |-> !irq_request)
        else $error("request without global enable");
    periph_irq_a: assert property (ic_w_r[7] && ic_w_r[6] &&
            |(peripheral_irq_enable_out & periph_flags) |-> ##[0:2] irq_request)
        else $error("peripheral request missing");
endmodule // core_regs_chk

bind core_status_option_irq_regs core_regs_chk chk_i (.*);

/* File: testbench/test_core_status_option_irq_regs.sv */
// Self-checking bench for the core register bank
`timescale 1ns/1ps
`include "core_sfr_map.vh"
module test_core_status_option_irq_regs;
    logic       clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, flags_upd_z = 1'b0, flags_upd_dc = 1'b0, flags_upd_c = 1'b0;
    logic       result_zero = 1'b0, result_dc = 1'b0, result_c = 1'b0, watchdog_clear_instr = 1'b0, sleep_instr = 1'b0;
    logic       wdt_timeout = 1'b0, timer0_overflow = 1'b0, ext_irq_pin = 1'b0, port_b_read = 1'b0;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00, periph_flags = 8'h00, reg_rdata, peripheral_irq_enable_out;
    logic [3:0] port_b_hi_pins = 4'h0, timer0_div_log2, wdt_div_log2;
    logic [2:0] prescaler_rate;
    logic [1:0] direct_bank;
    logic       indirect_bank_sel, pullup_disable_n, ext_irq_edge_sel, timer0_clk_src, timer0_ext_edge;
    logic       prescaler_assign, irq_request;
    int         err_total = 0, comparisons = 0;
    core_status_option_irq_regs dut (.*);
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // Update bits and results ride with the write, as one instruction
    task automatic wr(input logic [8:0] a, input logic [7:0] d,
                      input logic [2:0] u = 3'b000, input logic [2:0] r = 3'b000);
        @(negedge clock);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        {flags_upd_z, flags_upd_dc, flags_upd_c, result_zero, result_dc, result_c} = {u, r};
        @(negedge clock);
        {reg_wr, flags_upd_z, flags_upd_dc, flags_upd_c} = 4'h0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e, input string n);
        @(negedge clock);
        reg_addr = a;
        @(negedge clock);
        chk(n, reg_rdata, e);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask
    task automatic t_reset;
        rd(`STATUS_ADDR, `STATUS_RST, "status");
        rd(`OPTION_ADDR, `OPTION_RST, "option");
        rd(`INTCTL_ADDR_ALT, `INTCTL_RST, "intctl");
        rd(`PIE_ADDR, `PIE_RST, "pie");
        rd(9'h090, 8'h00, "unmapped");
        chk("wdt div", {4'h0, wdt_div_log2}, 8'h07);
        $display("reset test done");
    endtask
    task automatic t_power;
        pulse(sleep_instr);
        rd(`STATUS_ADDR_ALT, 8'h10, "sleep");
        wr(`STATUS_ADDR, 8'h6f);
        rd(`STATUS_ADDR, 8'h77, "read-only bits");
        chk("bank", {6'h0, direct_bank}, 8'h03);
        wr(`STATUS_ADDR_ALT, 8'h80);
        pulse(wdt_timeout);
        rd(`STATUS_ADDR, 8'h80, "timeout");
        chk("indirect", {7'h0, indirect_bank_sel}, 8'h01);
        pulse(watchdog_clear_instr);
        rd(`STATUS_ADDR, 8'h98, "wdt clear");
        $display("power flag test done");
    endtask
    task automatic t_flags;
        wr(`STATUS_ADDR, 8'h01, 3'b111, 3'b110);
        rd(`STATUS_ADDR, 8'h1e, "all flags");
        wr(`STATUS_ADDR, 8'h06, 3'b001, 3'b001);
        rd(`STATUS_ADDR, 8'h1f, "carry only");
        $display("flag override test done");
    endtask
    task automatic t_option;
        logic [31:0] tbl = 32'h00075aff;
        logic [7:0] o;
        for (int i = 0; i < 4; i++) begin
            o = tbl[31 - 8 * i -: 8];
            wr(`OPTION_ADDR, o);
            rd(`OPTION_ADDR, o, "option");
            chk("fields", {pullup_disable_n, ext_irq_edge_sel, timer0_clk_src, timer0_ext_edge,
                prescaler_assign, prescaler_rate}, o);
            chk("t0 div", {4'h0, timer0_div_log2}, o[3] ? 8'h00 : {5'h0, o[2:0]} + 8'h01);
            chk("wdt div", {4'h0, wdt_div_log2}, o[3] ? {5'h0, o[2:0]} : 8'h00);
        end
        $display("option test done");
    endtask
    task automatic t_irq;
        wr(`INTCTL_ADDR, 8'h00);
        pulse(timer0_overflow);
        rd(`INTCTL_ADDR, 8'h04, "t0 flag");
        chk("irq masked", {7'h0, irq_request}, 8'h00);
        wr(`INTCTL_ADDR_ALT, 8'ha4);
        rd(`INTCTL_ADDR, 8'ha4, "t0 on");
        chk("irq t0", {7'h0, irq_request}, 8'h01);
        wr(`INTCTL_ADDR, 8'h00);
        pulse(ext_irq_pin);
        repeat (6) @(negedge clock);
        rd(`INTCTL_ADDR, 8'h02, "ext edge");
        wr(`OPTION_ADDR, 8'hbf);
        wr(`INTCTL_ADDR, 8'h00);
        pulse(ext_irq_pin);
        repeat (6) @(negedge clock);
        rd(`INTCTL_ADDR, 8'h02, "ext fall");
        chk("edge sel", {7'h0, ext_irq_edge_sel}, 8'h00);
        wr(`INTCTL_ADDR, 8'h00);
        port_b_hi_pins = 4'h5;
        repeat (6) @(negedge clock);
        rd(`INTCTL_ADDR, 8'h01, "port change");
        pulse(port_b_read);
        wr(`INTCTL_ADDR, 8'h00);
        rd(`INTCTL_ADDR, 8'h00, "change clear");
        wr(`PIE_ADDR, 8'h01);
        periph_flags = 8'h01;
        wr(`INTCTL_ADDR, 8'h80);
        rd(`PIE_ADDR, 8'h01, "pie");
        chk("pie out", peripheral_irq_enable_out, 8'h01);
        chk("no periph_irq_en", {7'h0, irq_request}, 8'h00);
        wr(`INTCTL_ADDR, 8'hc0);
        rd(`INTCTL_ADDR, 8'hc0, "periph_irq_en");
        chk("irq periph", {7'h0, irq_request}, 8'h01);
        $display("interrupt test done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (16) @(negedge clock);
        rst = 1'b0;
        t_reset;
        t_power;
        t_flags;
        t_option;
        t_irq;
        print_verdict;
    end
    // Whole run needs about 130 cycles
    initial begin
        #20000;
        err_total++;
        print_verdict;
    end
endmodule // test_core_status_option_irq_regs
